/* File: hw/hbf_pkg.sv */
// Shared constants for the full-bridge control and protection block
package hbf_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	// Overcurrent persistence time, in nanoseconds
	localparam int unsigned OC_FILTER_NS    = 5100;
	// Overcurrent trips after more than this many cycles
	localparam int unsigned OC_FILTER_CYC   = (OC_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Dead time between upper and lower switches, in nanoseconds
	localparam int unsigned DEAD_TIME_NS    = 200;
	localparam int unsigned DEAD_TIME_CYC_R = (DEAD_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned DEAD_TIME_CYC   = (DEAD_TIME_CYC_R < 1) ? 1 : DEAD_TIME_CYC_R;

	// Desired state of one bridge output
	typedef enum logic [1:0] {
		HBF_LEG_OFF,
		HBF_LEG_LOW,
		HBF_LEG_HIGH
	} hbf_leg_e;
endpackage

/* File: hw/hbf_leg.sv */
// One bridge leg: gate drive with dead time between upper and lower switches
`timescale 1ns/100ps
module hbf_leg
	import hbf_pkg::*;
#(
	parameter int unsigned DEAD_CYC = DEAD_TIME_CYC
) (
	// Clock and reset
	input  wire logic     clk_in,
	input  wire logic     rst_n_in,
	// Requested output state
	input  wire hbf_leg_e target_in,
	// Gate drives
	output logic          upper_on_out,
	output logic          lower_on_out
);
	logic [7:0] dead_cnt_ff;
	logic [7:0] nxt_dead_cnt;
	logic       upper_ff;
	logic       nxt_upper;
	logic       lower_ff;
	logic       nxt_lower;

	always_comb begin
		nxt_upper    = upper_ff;
		nxt_lower    = lower_ff;
		nxt_dead_cnt = dead_cnt_ff;
		if (target_in == HBF_LEG_OFF) begin
			// Switching off is immediate; faults must not wait
			nxt_upper    = 1'b0;
			nxt_lower    = 1'b0;
			nxt_dead_cnt = 8'(DEAD_CYC);
		end else if ((target_in == HBF_LEG_HIGH && lower_ff) ||
				(target_in == HBF_LEG_LOW && upper_ff)) begin
			// Opposite switch off first, then wait dead time
			nxt_upper    = 1'b0;
			nxt_lower    = 1'b0;
			nxt_dead_cnt = 8'(DEAD_CYC);
		end else if (dead_cnt_ff != 8'h00) begin
			nxt_dead_cnt = dead_cnt_ff - 8'h01;
		end else begin
			nxt_upper = (target_in == HBF_LEG_HIGH);
			nxt_lower = (target_in == HBF_LEG_LOW);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			upper_ff    <= 1'b0;
			lower_ff    <= 1'b0;
			dead_cnt_ff <= 8'(DEAD_CYC);
		end else begin
			upper_ff    <= nxt_upper;
			lower_ff    <= nxt_lower;
			dead_cnt_ff <= nxt_dead_cnt;
		end
	end

	assign upper_on_out = upper_ff;
	assign lower_on_out = lower_ff;

	never_both_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(upper_ff && lower_ff))
		else $error("Both switches of a leg on");
	dead_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(lower_ff) |-> !upper_ff [*2])
		else $error("No dead gap after lower off");
	upper_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(upper_ff) |-> !lower_ff [*2])
		else $error("No dead gap after upper off");
endmodule

/* File: hw/hbf_ctrl.sv */
// Full-bridge control: input decode, fault latches, overcurrent filter
// Contract
// - Overvoltage forces all outputs high impedance
// - Overvoltage shutdown self-recovers, never latches
// - Overtemperature forces all outputs high impedance
// - Thermal/overcurrent latch until both inputs low
// - Any of four transistor sensors counts
// - Overcurrent trips only after filter time
// - Overcurrent trip turns every transistor off
// - PWM toggling alternates drive and brake
// - Dead time between upper and lower switching
// - Decode inputs to brake/forward/reverse/stop
`timescale 1ns/100ps
module hbf_ctrl
	import hbf_pkg::*;
#(
	parameter int unsigned OC_CYC   = OC_FILTER_CYC,
	parameter int unsigned DEAD_CYC = DEAD_TIME_CYC
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Host control pins
	input  wire logic       control_input_a_in,
	input  wire logic       control_input_b_in,
	// Analog detectors
	input  wire logic       overvoltage_in,
	input  wire logic       overtemp_in,
	input  wire logic [3:0] overcurrent_in,
	// Gate drives: index 0 upper A, 1 lower A, 2 upper B, 3 lower B
	output logic [3:0]      gate_on_out,
	// Status
	output logic            overvoltage_shutdown_out,
	output logic            thermal_shutdown_out,
	output logic            overcurrent_shutdown_out
);
	// Two-stage synchronisers for all asynchronous inputs
	logic [7:0] sync1_ff;
	logic [7:0] sync2_ff;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
		end else begin
			sync1_ff <= {overcurrent_in, overtemp_in, overvoltage_in,
				control_input_b_in, control_input_a_in};
			sync2_ff <= sync1_ff;
		end
	end

	logic       in_a;
	logic       in_b;
	logic       ov_det;
	logic       ot_det;
	logic [3:0] oc_det;
	assign in_a   = sync2_ff[0];
	assign in_b   = sync2_ff[1];
	assign ov_det = sync2_ff[2];
	assign ot_det = sync2_ff[3];
	assign oc_det = sync2_ff[7:4];

	// Fault latches and overcurrent filter
	logic        therm_ff;
	logic        nxt_therm;
	logic        ocl_ff;
	logic        nxt_ocl;
	logic [15:0] oc_cnt_ff;
	logic [15:0] nxt_oc_cnt;
	logic        release_req;
	logic        oc_trip;

	assign release_req = !in_a && !in_b;
	assign oc_trip     = (|oc_det) && (oc_cnt_ff >= 16'(OC_CYC));

	always_comb begin
		nxt_oc_cnt = 16'h0000;
		if (|oc_det) begin
			// Saturate so a stuck sensor cannot wrap the filter
			nxt_oc_cnt = (oc_cnt_ff == 16'hFFFF) ? oc_cnt_ff : oc_cnt_ff + 16'h0001;
		end
		nxt_therm = therm_ff;
		nxt_ocl   = ocl_ff;
		// Set wins over release when both happen at once
		if (release_req) begin
			nxt_therm = 1'b0;
			nxt_ocl   = 1'b0;
		end
		if (ot_det) begin
			nxt_therm = 1'b1;
		end
		if (oc_trip) begin
			nxt_ocl = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			therm_ff  <= 1'b0;
			ocl_ff    <= 1'b0;
			oc_cnt_ff <= 16'h0000;
		end else begin
			therm_ff  <= nxt_therm;
			ocl_ff    <= nxt_ocl;
			oc_cnt_ff <= nxt_oc_cnt;
		end
	end

	// Overvoltage follows the detector level, no latch
	logic fault_any;
	assign fault_any = ov_det || therm_ff || ocl_ff;

	// Decode requested leg states
	hbf_leg_e tgt_a;
	hbf_leg_e tgt_b;
	always_comb begin
		tgt_a = HBF_LEG_OFF;
		tgt_b = HBF_LEG_OFF;
		if (!fault_any) begin
			// Each input combination maps straight to drive, brake or stop
			unique case ({in_a, in_b})
				2'b11: begin
					tgt_a = HBF_LEG_LOW;
					tgt_b = HBF_LEG_LOW;
				end
				2'b01: begin
					tgt_a = HBF_LEG_LOW;
					tgt_b = HBF_LEG_HIGH;
				end
				2'b10: begin
					tgt_a = HBF_LEG_HIGH;
					tgt_b = HBF_LEG_LOW;
				end
				2'b00: begin
					tgt_a = HBF_LEG_OFF;
					tgt_b = HBF_LEG_OFF;
				end
			endcase
		end
	end

	// Legs insert dead time themselves, so host direct reversal is safe
	hbf_leg #(
		.DEAD_CYC (DEAD_CYC)
	) u_leg_a (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.target_in    (tgt_a),
		.upper_on_out (gate_on_out[0]),
		.lower_on_out (gate_on_out[1])
	);
	hbf_leg #(
		.DEAD_CYC (DEAD_CYC)
	) u_leg_b (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.target_in    (tgt_b),
		.upper_on_out (gate_on_out[2]),
		.lower_on_out (gate_on_out[3])
	);

	assign overvoltage_shutdown_out = ov_det;
	assign thermal_shutdown_out     = therm_ff;
	assign overcurrent_shutdown_out = ocl_ff;

	// Drive checks allow eight cycles, enough for a reversal with the default dead time
	ov_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ov_det |=> gate_on_out == 4'h0)
		else $error("Gate on during overvoltage");
	ov_recover_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(ov_det) && !therm_ff && !ocl_ff && (in_a || in_b)
		|-> tgt_a != HBF_LEG_OFF && tgt_b != HBF_LEG_OFF)
		else $error("Overvoltage latched");
	ot_latch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ot_det |=> therm_ff ##1 gate_on_out == 4'h0)
		else $error("Thermal not latched");
	latch_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		therm_ff && !release_req |=> therm_ff)
		else $error("Thermal latch lost");
	therm_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		therm_ff && release_req && !ot_det |=> !therm_ff)
		else $error("Thermal not released");
	latch_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ocl_ff && release_req && !oc_trip |=> !ocl_ff)
		else $error("Overcurrent not released");
	oc_restart_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(|oc_det) |=> oc_cnt_ff == 16'h0000)
		else $error("Overcurrent filter not restarted");
	oc_short_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(|oc_det) && oc_cnt_ff < 16'(OC_CYC) && !ocl_ff |=> !ocl_ff)
		else $error("Short overcurrent tripped");
	oc_filter_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(ocl_ff) |-> $past(oc_cnt_ff) >= 16'(OC_CYC))
		else $error("Overcurrent tripped early");
	oc_any_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		oc_trip |=> ocl_ff ##1 gate_on_out == 4'h0)
		else $error("Overcurrent not acted on");
	fault_force_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fault_any |=> gate_on_out == 4'h0)
		else $error("Gate on during fault");
	short_brake_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		in_a && in_b && !fault_any [*8] |-> gate_on_out == 4'b1010)
		else $error("Brake not applied");
	fwd_drive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!in_a && in_b && !fault_any [*8] |-> gate_on_out == 4'b0110)
		else $error("Forward drive not applied");
	rev_drive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		in_a && !in_b && !fault_any [*8] |-> gate_on_out == 4'b1001)
		else $error("Reverse drive not applied");
	stop_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!in_a && !in_b |=> gate_on_out == 4'h0)
		else $error("Gate on in stop");

	brake_cov_c: cover property (@(posedge clk_in) gate_on_out == 4'b1010);
	rev_cov_c: cover property (@(posedge clk_in) gate_on_out == 4'b1001);
	fwd_cov_c: cover property (@(posedge clk_in) gate_on_out == 4'b0110);
	oc_trip_cov_c: cover property (@(posedge clk_in) $rose(ocl_ff));
	therm_rel_cov_c: cover property (@(posedge clk_in) $fell(therm_ff));
endmodule

/* File: dv/hbf_host_model.sv */
// Host controller model driving the two control inputs
`timescale 1ns/100ps
module hbf_host_model (
	// Clock
	input  wire logic clk_in,
	// Control pins
	output logic      ctl_a_out,
	output logic      ctl_b_out
);
	initial begin
		ctl_a_out = 1'h0;
		ctl_b_out = 1'h0;
	end

	// No off interval between modes: the device owns dead time
	task automatic drive(input logic a, input logic b);
		@(negedge clk_in);
		ctl_a_out = a;
		ctl_b_out = b;
	endtask

	// Apart from reset, both low together is the only way out of a latched fault
	task automatic release_latch();
		drive(1'h0, 1'h0);
	endtask
endmodule

/* File: dv/hbridge_fault_protect_ctrl_tb.sv */
// Self-checking bench for the full-bridge control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module hbridge_fault_protect_ctrl_tb;
	logic       clk_in = 1'h0;
	logic       rst_n_in = 1'h0;
	logic       ov = 1'h0;
	logic       ot = 1'h0;
	logic [3:0] oc = 4'h0;
	wire        a;
	wire        b;
	logic [3:0] gates;
	logic       ov_s;
	logic       th_s;
	logic       oc_s;
	int         mismatches = 0;
	int         num_checks = 0;

	always #20 clk_in = ~clk_in;

	hbf_host_model u_host (.clk_in(clk_in), .ctl_a_out(a), .ctl_b_out(b));
	localparam int unsigned OC_N   = 4;
	localparam int unsigned DEAD_N = 2;

	hbf_ctrl #(.OC_CYC(OC_N), .DEAD_CYC(DEAD_N)) u_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.control_input_a_in(a), .control_input_b_in(b),
		.overvoltage_in(ov), .overtemp_in(ot), .overcurrent_in(oc),
		.gate_on_out(gates), .overvoltage_shutdown_out(ov_s),
		.thermal_shutdown_out(th_s), .overcurrent_shutdown_out(oc_s));

	// Index 0 upper A, 1 lower A, 2 upper B, 3 lower B
	function automatic logic [3:0] exp_g(input logic [1:0] m);
		case (m)
			2'h3: exp_g = 4'ha;
			2'h1: exp_g = 4'h6;
			2'h2: exp_g = 4'h9;
			default: exp_g = 4'h0;
		endcase
	endfunction

	always @(negedge clk_in) begin
		if (rst_n_in) begin
			`CHK("leg_overlap", 1'h0, (gates[0] && gates[1]) || (gates[2] && gates[3]));
		end
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// Ten cycles covers sync, decode and dead time
	task automatic mode(input logic [1:0] m);
		u_host.drive(m[1], m[0]);
		wait_n(10);
	endtask

	task automatic t_decode();
		logic [1:0] seq [8] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0};
		foreach (seq[i]) begin
			mode(seq[i]);
			`CHK("gates", exp_g(seq[i]), gates);
		end
	endtask

	task automatic t_ov();
		mode(2'h1);
		ov = 1'h1;
		wait_n(5);
		`CHK("gates", 4'h0, gates);
		`CHK("ov_stat", 1'h1, ov_s);
		ov = 1'h0;
		wait_n(10);
		`CHK("gates", 4'h6, gates);
		`CHK("ov_stat", 1'h0, ov_s);
	endtask

	task automatic t_tsd();
		mode(2'h2);
		ot = 1'h1;
		wait_n(5);
		`CHK("gates", 4'h0, gates);
		// Release while the detector still reports: set wins
		u_host.release_latch();
		wait_n(10);
		`CHK("th_stat", 1'h1, th_s);
		mode(2'h3);
		ot = 1'h0;
		wait_n(10);
		`CHK("gates", 4'h0, gates);
		`CHK("th_stat", 1'h1, th_s);
		u_host.release_latch();
		wait_n(10);
		`CHK("th_stat", 1'h0, th_s);
		mode(2'h2);
		`CHK("gates", 4'h9, gates);
	endtask

	task automatic t_oc();
		for (int i = 0; i < 4; i++) begin
			mode(2'h3);
			oc[i] = 1'h1;
			// Exactly the filter length must not trip
			wait_n(OC_N);
			oc = 4'h0;
			wait_n(8);
			`CHK("oc_stat", 1'h0, oc_s);
			oc[i] = 1'h1;
			wait_n(12);
			`CHK("oc_stat", 1'h1, oc_s);
			`CHK("gates", 4'h0, gates);
			oc = 4'h0;
			mode(2'h0);
			`CHK("oc_stat", 1'h0, oc_s);
		end
	endtask

	// Reset in mid-run must drop a held latch and restart cleanly
	task automatic t_rst();
		mode(2'h3);
		ot = 1'h1;
		wait_n(5);
		rst_n_in = 1'h0;
		wait_n(3);
		`CHK("th_stat", 1'h0, th_s);
		`CHK("gates", 4'h0, gates);
		ot = 1'h0;
		rst_n_in = 1'h1;
		mode(2'h3);
		`CHK("gates", 4'ha, gates);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		wait_n(3);
		rst_n_in = 1'h1;
		`CHK("gates", 4'h0, gates);
		t_decode();
		t_ov();
		t_tsd();
		t_oc();
		t_rst();
		end_sim();
	end

	// Tests need about 400 cycles; allow over six times that
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
endmodule
